// ---- logic/edb_pkg.sv ----
//
// ****************************************
// Contract
// [RULE_01] Single-bit error: raise single flag, output corrected word, array unchanged.
// [RULE_02] Two or more bit errors: raise multi flag, output stored word uncorrected.
// [RULE_03] Both flags appear in the same cycle as their data word.
// [RULE_04] At 64-bit width only flag bit 0 is meaningful; bit 1 ignored.
// [RULE_05] Error checking only for 64/128-bit widths; check bits at 71:64, 143:136.
// [RULE_06] Checking enabled with other widths: check-bit positions ignored in and out.
// [RULE_07] User enables repacking for 64-bit with 9-family or 144-bit pairings.
// [RULE_08] Read widths of 36 or less never paired with write width 72 or 144.
// [RULE_09] User puts word address in upper address bits and zeroes the low bits.
// [RULE_10] 128-bit write: halves on 135:72 and 63:0, check bytes zero; narrow uses low bits.
// [RULE_11] Read uses same justification; 128-bit halves on 135:72 and 63:0.
// [RULE_12] Latched mode: read data out one cycle after the read.
// [RULE_13] Registered mode: extra output register, two cycles latency.
// [RULE_14] Latch clears on low latch clear, else loads on read enable, else holds.
// [RULE_15] Output register with enable high: clears on low clear, else loads latch.
// [RULE_16] Write enable stores write data at write address on next edge.
// [RULE_17] Write enable with no byte-mask bit leaves the array unchanged.
// [RULE_18] Same-cycle write and read of one location: write wins, read data invalid.
// [RULE_19] Check generator enabled: input check bits ignored, generated bits stored.
// [RULE_20] One mask bit per 8- or 9-bit input byte; only masked bytes written.
// [RULE_21] Flags low when checking disabled or no error found.
// [RULE_22] Latch and register clears also force both flags to zero.
// ****************************************
`default_nettype none

package edb_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W   = 14;
  localparam int DATA_W   = 144;
  localparam int ROW_AW   = 9;
  localparam int ROW_LSB  = 5;
  localparam int HALF_W   = 72;
  localparam int USER_W   = 64;
  localparam int CHK_W    = 8;
  localparam int CHK_LO   = 64;
  localparam int CHK_HI   = 136;
  localparam int UP_LSB   = 72;
  localparam int MASK_W   = 18;
  localparam int SYN_W    = 7;
  localparam int NIB_W    = 4;

  // ****************************************
  // Defaults and reset values
  // ****************************************
  localparam int DEF_WIDTH   = 72;
  localparam int DEF_BYTE_W  = 9;
  localparam logic [DATA_W-1:0] DOUT_RST = 144'h0;
  localparam logic [1:0]        FLAG_RST = 2'h0;

endpackage

`default_nettype wire

// ---- logic/edb_ram.sv ----
// Our own choices: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module edb_ram
  import edb_pkg::*;
#(
  parameter int RD_W    = DEF_WIDTH,
  parameter int WR_W    = DEF_WIDTH,
  parameter int BYTE_W  = DEF_BYTE_W,
  parameter bit OUT_REG = 1'b0,
  parameter bit ECC_ENC = 1'b0,
  parameter bit ECC_DEC = 1'b0
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              wren_i,
  input  wire logic [MASK_W-1:0] we_mask_i,
  input  wire logic [ADDR_W-1:0] wraddr_i,
  input  wire logic [DATA_W-1:0] din_i,
  input  wire logic              rden_i,
  input  wire logic [ADDR_W-1:0] rdaddr_i,
  input  wire logic              outlatch_rstn_i,
  input  wire logic              outreg_rstn_i,
  input  wire logic              outreg_ce_i,
  output logic      [DATA_W-1:0] dout_o,
  output logic      [1:0]        sbit_error_o,
  output logic      [1:0]        dbit_error_o
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Bit offset of a word lane inside a row
  // Lanes sit on a nine-bit grid; eight-bit words use the low bits of a slot
  function automatic logic [7:0] lane_off(
    input logic [ADDR_W-1:0] a,
    input int                w
  );
    logic [7:0] o;
    o = 8'h00;
    case (w)
      144, 128: o = 8'h00;
      72, 64: o = a[4] ? 8'h48 : 8'h00;
      36, 32: o = 8'h24 * {6'h00, a[4:3]};
      18, 16: o = 8'h12 * {5'h00, a[4:2]};
      9, 8: o = 8'h09 * {4'h0, a[4:1]};
      default: o = 8'h09 * {4'h0, a[4:1]} + (a[0] ? 8'h04 : 8'h00);
    endcase
    return o;
  endfunction

  // True for widths that carry check bytes
  function automatic bit ecc_w(input int w);
    return (w == 64) || (w == 128);
  endfunction

  // Data bits a width uses, check lanes apart
  function automatic logic [DATA_W-1:0] data_mask(input int w);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (w == 144)
        m[i] = 1'b1;
      else if (w == 128)
        m[i] = (i < CHK_LO) || (i >= UP_LSB && i < CHK_HI);
      else
        m[i] = (i < w);
    end
    return m;
  endfunction

  // Check lanes of a width
  function automatic logic [DATA_W-1:0] chk_mask(input int w);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (w == 64 || w == 128)
        m[i] = (i >= CHK_LO && i < UP_LSB);
      if (w == 128 && i >= CHK_HI)
        m[i] = 1'b1;
    end
    return m;
  endfunction

  // Byte mask spread over data bits
  // Nine-bit bytes skip mask bit 8, which has no lane of its own
  function automatic logic [DATA_W-1:0] spread(
    input logic [MASK_W-1:0] we
  );
    logic [DATA_W-1:0] m;
    int                j;
    m = '0;
    for (int b = 0; b < DATA_W; b++) begin
      j = b / BYTE_W;
      if (BYTE_W == 9 && j >= 8)
        j = j + 1;
      m[b] = we[j];
    end
    return m;
  endfunction

  // ****************************************
  // Check code
  // ****************************************

  // Check byte of a 64-bit word
  // Seven syndrome bits over positions 1 to 71, powers of two skipped
  // Top bit is overall parity, which tells single from double errors
  function automatic logic [CHK_W-1:0] enc(
    input logic [USER_W-1:0] d
  );
    logic [CHK_W-1:0] c;
    int               j;
    c = '0;
    j = 0;
    for (int p = 1; p < HALF_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int k = 0; k < SYN_W; k++) begin
          if (((p >> k) & 1) == 1)
            c[k] = c[k] ^ d[j];
        end
        j = j + 1;
      end
    end
    c[CHK_W-1] = ^{d, c[SYN_W-1:0]};
    return c;
  endfunction

  // Check and correct one 72-bit half: {multi, single, data}
  function automatic logic [USER_W+1:0] dec(
    input logic [HALF_W-1:0] w
  );
    logic [SYN_W-1:0]  syn;
    logic [CHK_W-1:0]  c;
    logic [USER_W-1:0] d;
    logic              par;
    logic              sgl;
    logic              dbl;
    int                j;
    c   = enc(w[USER_W-1:0]);
    syn = c[SYN_W-1:0] ^ w[CHK_LO+SYN_W-1:CHK_LO];
    par = ^w;
    d   = w[USER_W-1:0];
    sgl = par;
    dbl = (syn != '0) && !par;
    j   = 0;
    for (int p = 1; p < HALF_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (par && syn == p[SYN_W-1:0])
          d[j] = ~d[j];
        j = j + 1;
      end
    end
    return {dbl, sgl, d};
  endfunction

  // ****************************************
  // Width-derived constants
  // ****************************************
  // Checking runs only at widths that carry check bytes
  localparam bit WR_ECC = ECC_ENC && ecc_w(WR_W); // RULE_05
  localparam bit RD_ECC = ECC_DEC && ecc_w(RD_W); // RULE_05
  localparam logic [DATA_W-1:0] WR_DM = data_mask(WR_W);
  localparam logic [DATA_W-1:0] WR_CM = chk_mask(WR_W);
  localparam logic [DATA_W-1:0] RD_CM = chk_mask(RD_W);
  localparam logic [DATA_W-1:0] CHK_ALL = chk_mask(128);
  localparam logic [DATA_W-1:0] RD_DM = data_mask(RD_W) | RD_CM;
  // Check positions dropped when checking is on at other widths
  localparam logic [DATA_W-1:0] WR_CUT =
    (ECC_ENC && !ecc_w(WR_W)) ? CHK_ALL : '0; // RULE_06
  localparam logic [DATA_W-1:0] RD_CUT =
    (ECC_DEC && !ecc_w(RD_W)) ? CHK_ALL : '0; // RULE_06

  // ****************************************
  // Storage
  // ****************************************
  // One row per 144-bit word; narrower words are lanes of a row
  logic [DATA_W-1:0] mem [0:(1<<ROW_AW)-1];

  // ****************************************
  // Write path
  // ****************************************
  wire logic [ROW_AW-1:0] wr_row;
  wire logic [7:0]        wr_off;
  wire logic [DATA_W-1:0] wr_be;
  wire logic [CHK_W-1:0]  enc_lo;
  wire logic [CHK_W-1:0]  enc_hi;
  wire logic              any_lo;
  wire logic              any_hi;
  wire logic [DATA_W-1:0] wr_gen;
  wire logic [DATA_W-1:0] wr_gbe;
  wire logic [DATA_W-1:0] wr_word;
  wire logic [DATA_W-1:0] wr_en;
  wire logic [DATA_W-1:0] wr_keep;
  wire logic [DATA_W-1:0] wr_val;
  wire logic [DATA_W-1:0] next_row;

  // Row from the upper address bits, lane from the low ones
  assign wr_row = wraddr_i[ADDR_W-1:ROW_LSB]; // RULE_09
  assign wr_off = lane_off(wraddr_i, WR_W);
  // One enable per data bit from the byte mask
  assign wr_be  = spread(we_mask_i); // RULE_20
  // Check bytes and write activity of each half
  assign enc_lo = enc(din_i[USER_W-1:0]);
  assign enc_hi = enc(din_i[CHK_HI-1:UP_LSB]);
  assign any_lo = |we_mask_i[7:0];
  assign any_hi = |we_mask_i[16:9];

  // Generated check bytes replace the input ones
  assign wr_gen = {enc_hi, din_i[CHK_HI-1:UP_LSB], enc_lo,
                   din_i[USER_W-1:0]}; // RULE_19
  // Check byte written with any data byte of its half
  assign wr_gbe = {{CHK_W{any_hi}}, wr_be[CHK_HI-1:UP_LSB],
                   {CHK_W{any_lo}}, wr_be[USER_W-1:0]};
  assign wr_word = WR_ECC ? wr_gen : din_i; // RULE_19
  assign wr_en   = (WR_ECC ? wr_gbe : wr_be) & (WR_DM | WR_CM)
                 & ~WR_CUT; // RULE_06

  // ****************************************
  // Lane placement
  // ****************************************
  // Enables and data shifted into the addressed lane
  assign wr_keep = wr_en << wr_off; // RULE_17
  assign wr_val  = (wr_word & wr_en) << wr_off; // RULE_10
  // Unmasked bits keep what the row already holds
  assign next_row = (mem[wr_row] & ~wr_keep) | wr_val;

  // ****************************************
  // Write commit
  // ****************************************
  // Row update on write enable; the array is never reset
  always_ff @(posedge mclk_i) begin
    if (wren_i) begin // RULE_16
      mem[wr_row] <= next_row; // RULE_18
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire logic [ROW_AW-1:0] rd_row;
  wire logic [7:0]        rd_off;
  wire logic [DATA_W-1:0] rd_raw;
  wire logic [USER_W+1:0] dec_lo;
  wire logic [USER_W+1:0] dec_hi;
  wire logic              hi_use;
  wire logic [DATA_W-1:0] rd_plain;
  wire logic [DATA_W-1:0] rd_fix;
  wire logic [DATA_W-1:0] next_lat;
  wire logic [1:0]        next_sbe;
  wire logic [1:0]        next_dbe;

  // Row and lane of the read word, same justification as writes
  assign rd_row = rdaddr_i[ADDR_W-1:ROW_LSB]; // RULE_11
  assign rd_off = lane_off(rdaddr_i, RD_W);
  // Old contents seen on a same-cycle collision
  assign rd_raw = mem[rd_row] >> rd_off; // RULE_18
  // Both halves always decoded; the upper result counts only at 128 bits
  assign dec_lo = dec(rd_raw[HALF_W-1:0]);
  assign dec_hi = dec(rd_raw[DATA_W-1:HALF_W]);
  assign hi_use = (RD_W == 128);

  // Justified read word, unused bits zero
  assign rd_plain = rd_raw & RD_DM & ~RD_CUT; // RULE_11

  // ****************************************
  // Error correction
  // ****************************************
  // Corrected halves; stored word kept on multi-bit errors
  assign rd_fix = {rd_plain[DATA_W-1:CHK_HI],
                   hi_use ? dec_hi[USER_W-1:0] : rd_plain[CHK_HI-1:UP_LSB],
                   rd_plain[UP_LSB-1:CHK_LO],
                   dec_lo[USER_W-1:0]}; // RULE_01
  assign next_lat = RD_ECC ? rd_fix : rd_plain; // RULE_02

  // ****************************************
  // Error flags
  // ****************************************
  // Flags only from an active checker; bit 1 only at 128 bits
  assign next_sbe = RD_ECC ? {hi_use & dec_hi[USER_W],
                              dec_lo[USER_W]} : FLAG_RST; // RULE_21
  assign next_dbe = RD_ECC ? {hi_use & dec_hi[USER_W+1],
                              dec_lo[USER_W+1]} : FLAG_RST; // RULE_04

  // ****************************************
  // Output latch
  // ****************************************
  logic [DATA_W-1:0] lat_data;
  logic [1:0]        lat_sbe;
  logic [1:0]        lat_dbe;

  // Clear wins over read; flags travel with data
  // A read that meets a clear is lost and must be issued again
  always_ff @(posedge mclk_i) begin
    if (rst_i || !outlatch_rstn_i) begin // RULE_14
      lat_data <= DOUT_RST;
      lat_sbe  <= FLAG_RST; // RULE_22
      lat_dbe  <= FLAG_RST;
    end else if (rden_i) begin // RULE_12
      lat_data <= next_lat;
      lat_sbe  <= next_sbe; // RULE_03
      lat_dbe  <= next_dbe;
    end
  end

  // ****************************************
  // Output register
  // ****************************************
  logic [DATA_W-1:0] reg_data;
  logic [1:0]        reg_sbe;
  logic [1:0]        reg_dbe;

  // Clear acts only while the enable is high
  // Block reset clears the stage whatever the enable
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_data <= DOUT_RST;
      reg_sbe  <= FLAG_RST;
      reg_dbe  <= FLAG_RST;
    end else if (outreg_ce_i) begin // RULE_15
      if (!outreg_rstn_i) begin
        reg_data <= DOUT_RST;
        reg_sbe  <= FLAG_RST; // RULE_22
        reg_dbe  <= FLAG_RST;
      end else begin // RULE_13
        reg_data <= lat_data;
        reg_sbe  <= lat_sbe; // RULE_03
        reg_dbe  <= lat_dbe;
      end
    end
  end

  // ****************************************
  // Output select
  // ****************************************
  // Registered mode shows the second stage, latched mode the first
  assign dout_o       = OUT_REG ? reg_data : lat_data; // RULE_13
  assign sbit_error_o = OUT_REG ? reg_sbe : lat_sbe; // RULE_03
  assign dbit_error_o = OUT_REG ? reg_dbe : lat_dbe;

endmodule

`default_nettype wire

// ---- tb/edb_fabric.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// User fabric side: word address and data justification
// ****************************************
module edb_fabric
  import edb_pkg::*;
(
  input  wire logic [ROW_AW-1:0] wr_row_i,
  input  wire logic [ROW_AW-1:0] rd_row_i,
  input  wire logic [127:0]      usr_data_i,
  output logic      [ADDR_W-1:0] wraddr_o,
  output logic      [ADDR_W-1:0] rdaddr_o,
  output logic      [DATA_W-1:0] din_o
);
  // Row in the upper address bits, low bits held at zero
  assign wraddr_o = {wr_row_i, {ROW_LSB{1'b0}}};
  assign rdaddr_o = {rd_row_i, {ROW_LSB{1'b0}}};
  // Halves on 135:72 and 63:0, check fields zero
  assign din_o    = {8'h00, usr_data_i[127:64], 8'h00, usr_data_i[63:0]};
endmodule

`default_nettype wire

// ---- tb/edb_ram_properties.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Read side output checks
// ****************************************
module edb_ram_props
  import edb_pkg::*;
#(
  parameter bit OUT_REG = 1'b1
) (
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire logic              rden_i,
  input wire logic              outlatch_rstn_i,
  input wire logic              outreg_rstn_i,
  input wire logic              outreg_ce_i,
  input wire logic [DATA_W-1:0] dout_o,
  input wire logic [1:0]        sbit_error_o,
  input wire logic [1:0]        dbit_error_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // Clears, holds and loads of the output stage
  a_rst_clears: assert property (disable iff (1'b0)
    rst_i |=> dout_o == '0 && sbit_error_o == 2'h0 && dbit_error_o == 2'h0)
    else $error("output not cleared by reset");
  a_reg_clear: assert property (
    OUT_REG && outreg_ce_i && !outreg_rstn_i |=> dout_o == '0 && (sbit_error_o | dbit_error_o) == 2'h0)
    else $error("output register clear missed");
  a_latch_clear: assert property (
    OUT_REG && !outlatch_rstn_i ##1 (outreg_ce_i && outreg_rstn_i) |=> dout_o == '0 && sbit_error_o == 2'h0)
    else $error("latch clear did not reach output");
  a_latch_hold: assert property (
    OUT_REG && outlatch_rstn_i && !rden_i && outreg_ce_i && outreg_rstn_i ##1 (outreg_ce_i && outreg_rstn_i)
    |=> $stable(dout_o))
    else $error("latch changed without a read");
  a_ce_hold: assert property (
    OUT_REG && (!outreg_ce_i) [*2] |=> $stable(dout_o) && $stable(sbit_error_o))
    else $error("output moved with enable low");
  a_dout_moves: assert property (
    OUT_REG && !$stable(dout_o) && !$past(rst_i) |-> $past(outreg_ce_i))
    else $error("data changed without register load");
  a_flags_move: assert property (
    OUT_REG && ($changed(sbit_error_o) || $changed(dbit_error_o)) && !$past(rst_i) |-> $past(outreg_ce_i))
    else $error("flags changed apart from data");
  a_flags_excl: assert property (
    (sbit_error_o & dbit_error_o) == 2'h0)
    else $error("single and multi flags both set");
endmodule

bind edb_ram edb_ram_props #(.OUT_REG(OUT_REG)) u_props (.mclk_i(mclk_i), .rst_i(rst_i), .rden_i(rden_i),
  .outlatch_rstn_i(outlatch_rstn_i), .outreg_rstn_i(outreg_rstn_i), .outreg_ce_i(outreg_ce_i),
  .dout_o(dout_o), .sbit_error_o(sbit_error_o), .dbit_error_o(dbit_error_o));

`default_nettype wire

// ---- tb/edb_ram_bench.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Bench: 128-bit decode-only memory, registered output
// ****************************************
module edb_ram_bench;
  import edb_pkg::*;

  logic              mclk_i = 1'b0;
  logic              rst_i  = 1'b1;
  logic              wren_i = 1'b0;
  logic              rden_i = 1'b0;
  logic              l_rstn = 1'b1;
  logic              r_rstn = 1'b1;
  logic              ce     = 1'b1;
  logic [MASK_W-1:0] mask   = 18'h00000;
  logic [ROW_AW-1:0] wr_row = 9'h000;
  logic [ROW_AW-1:0] rd_row = 9'h000;
  logic [127:0]      udat   = 128'h0;
  logic [ADDR_W-1:0] wraddr;
  logic [ADDR_W-1:0] rdaddr;
  logic [DATA_W-1:0] din;
  logic [DATA_W-1:0] dout;
  logic [1:0]        sbit;
  logic [1:0]        dbit;
  int                err_count  = 0;
  int                num_checks = 0;
  int                cycles     = 0;
  localparam logic [63:0] HI2 = 64'hC000_0000_0000_0000;

  // 200 MHz clock
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  edb_fabric fab (.wr_row_i(wr_row), .rd_row_i(rd_row), .usr_data_i(udat), .wraddr_o(wraddr), .rdaddr_o(rdaddr),
    .din_o(din));
  edb_ram #(.RD_W(128), .WR_W(128), .BYTE_W(8), .OUT_REG(1'b1), .ECC_DEC(1'b1)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .wren_i(wren_i), .we_mask_i(mask), .wraddr_i(wraddr), .din_i(din),
    .rden_i(rden_i), .rdaddr_i(rdaddr), .outlatch_rstn_i(l_rstn), .outreg_rstn_i(r_rstn), .outreg_ce_i(ce),
    .dout_o(dout), .sbit_error_o(sbit), .dbit_error_o(dbit));

  function automatic logic [DATA_W-1:0] ex(input logic [63:0] h, input logic [63:0] l);
    return {8'h00, h, 8'h00, l};
  endfunction

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] d, input logic [1:0] s, input logic [1:0] e);
    num_checks++;
    if (dout !== d || sbit !== s || dbit !== e) begin
      err_count++;
      $display("Error at %0t: dout %h flags %b %b", $time, dout, sbit, dbit);
    end
  endtask

  task automatic wr(input logic [ROW_AW-1:0] r, input logic [127:0] d, input logic [MASK_W-1:0] m);
    @(posedge mclk_i);
    wren_i <= 1'b1;
    wr_row <= r;
    udat   <= d;
    mask   <= m;
    @(posedge mclk_i);
    wren_i <= 1'b0;
  endtask

  // Read taken at the next edge, output checked one edge later
  task automatic rd(input logic [ROW_AW-1:0] r, input logic [DATA_W-1:0] d, input logic [1:0] s,
                    input logic [1:0] e);
    @(posedge mclk_i);
    rden_i <= 1'b1;
    rd_row <= r;
    @(posedge mclk_i);
    rden_i <= 1'b0;
    @(posedge mclk_i);
    #1 chk(d, s, e);
  endtask

  task automatic t_ecc();
    wr(9'h002, {HI2, 64'h3}, 18'h3FFFF);
    rd(9'h002, ex(HI2, 64'h3), 2'b00, 2'b11);
    wr(9'h001, 128'h0, 18'h3FFFF);
    rd(9'h001, '0, 2'b00, 2'b00);
    wr(9'h003, {64'h20, 64'h1}, 18'h3FFFF);
    rd(9'h003, '0, 2'b11, 2'b00);
    rd(9'h003, '0, 2'b11, 2'b00);
  endtask

  task automatic t_mask();
    wr(9'h002, 128'h0, 18'h000FF);
    rd(9'h002, ex(HI2, 64'h0), 2'b00, 2'b10);
    wr(9'h002, 128'h0, 18'h00000);
    rd(9'h002, ex(HI2, 64'h0), 2'b00, 2'b10);
  endtask

  task automatic t_clears();
    @(posedge mclk_i);
    rden_i <= 1'b1;
    rd_row <= 9'h002;
    l_rstn <= 1'b0;
    @(posedge mclk_i);
    rden_i <= 1'b0;
    l_rstn <= 1'b1;
    @(posedge mclk_i);
    #1 chk('0, 2'b00, 2'b00);
    @(posedge mclk_i);
    ce <= 1'b0;
    rd(9'h002, '0, 2'b00, 2'b00);
    @(posedge mclk_i);
    ce <= 1'b1;
    @(posedge mclk_i);
    #1 chk(ex(HI2, 64'h0), 2'b00, 2'b10);
    @(posedge mclk_i);
    r_rstn <= 1'b0;
    @(posedge mclk_i);
    r_rstn <= 1'b1;
    #1 chk('0, 2'b00, 2'b00);
  endtask

  // Same-row write and read in one cycle; the write must win
  task automatic t_collide();
    wr(9'h004, {64'h0, 64'h3}, 18'h3FFFF);
    @(posedge mclk_i);
    wren_i <= 1'b1;
    rden_i <= 1'b1;
    wr_row <= 9'h004;
    rd_row <= 9'h004;
    udat   <= 128'h0;
    @(posedge mclk_i);
    wren_i <= 1'b0;
    rden_i <= 1'b0;
    rd(9'h004, '0, 2'b00, 2'b00);
  endtask

  // Hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_ecc();
    t_mask();
    t_clears();
    t_collide();
    give_verdict();
  end
endmodule

`default_nettype wire
